// ### src/flash_host_pkg.sv
// flash host controller: shared constants, command codes, types
// assumes a 100 MHz clock; pin timing figures are rounded to whole cycles here
package flash_host_pkg;

  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int cyclesUp(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyclesUp

  localparam int ADDR_SETUP_NS  = 20;
  localparam int WE_PULSE_NS    = 50;
  localparam int WE_HOLD_NS     = 20;
  localparam int READ_ACCESS_NS = 120;   // covers access time plus three-flop sync
  localparam int WAKE_READ_NS   = 400;
  localparam int WAKE_WRITE_NS  = 1000;

  localparam logic [7:0] SETUP_CYC = 8'(cyclesUp(ADDR_SETUP_NS));
  localparam logic [7:0] PULSE_CYC = 8'(cyclesUp(WE_PULSE_NS));
  localparam logic [7:0] HOLD_CYC  = 8'(cyclesUp(WE_HOLD_NS));
  localparam logic [7:0] READ_CYC  = 8'(cyclesUp(READ_ACCESS_NS));
  localparam logic [7:0] WE_LOW_AT  = SETUP_CYC - 8'h01;
  localparam logic [7:0] WE_HIGH_AT = SETUP_CYC + PULSE_CYC - 8'h01;
  localparam logic [7:0] WR_END_AT  = SETUP_CYC + PULSE_CYC + HOLD_CYC - 8'h01;
  localparam logic [7:0] RD_END_AT  = READ_CYC - 8'h01;

  // ============================================================
  // device command codes
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;

  // device status bits
  localparam int BIT_READY        = 7;
  localparam int BIT_ERASE_FAIL   = 5;
  localparam int BIT_PROGRAM_FAIL = 4;
  localparam int BIT_SUPPLY_FAULT = 3;
  localparam logic [7:0] STATUS_INIT = 8'h80;   // upper five bits 10000
  localparam logic [7:0] ERR_MASK    = 8'h38;

  // ============================================================
  // own register map (byte offsets, one word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ    = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAIL  = 1;
  localparam int IRQ_REFUS = 2;
  localparam int IRQ_ABORT = 3;
  localparam int IRQ_W     = 4;

  localparam int ADDR_W = 20;

  // ============================================================
  // types
  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_READ_ARRAY  = 3'b001,
    OP_PROGRAM     = 3'b010,
    OP_ERASE       = 3'b011,
    OP_CLEAR       = 3'b100,
    OP_READ_STATUS = 3'b101,
    OP_SLEEP       = 3'b110,
    OP_WAKE        = 3'b111
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } state_type;

  typedef struct packed {
    logic              ceN;
    logic              weN;
    logic              oeN;
    logic              rpN;
    logic              dataOeN;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dataOut;
  } flash_pins_type;

  localparam flash_pins_type PINS_RESET = '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, rpN: 1'b0,
                                            dataOeN: 1'b1, addr: '0, dataOut: 8'h00};

endpackage : flash_host_pkg

// ### src/flash_pin_sync.sv
// three-flop synchroniser for flash pin inputs
// assumes pins change slowly against clk; output moves when stages two and three agree
`timescale 1ns/1ps
module flash_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ============================================================
  // chain; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      syncOut <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        syncOut <= s3_q;   // filters a bit caught mid-transition
      end
    end
  end

endmodule : flash_pin_sync

// ### src/flash_host_ctrl.sv
// flash host controller: AHB-Lite registers, command sequencer, pin engine
// assumes one byte-wide flash on the pins and one AHB-Lite master, zero wait states
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int WAKE_READ_CYC  = cyclesUp(WAKE_READ_NS),
  parameter int WAKE_WRITE_CYC = cyclesUp(WAKE_WRITE_NS)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output flash_pins_type   pins,
  input  wire logic [7:0]  flashDataIn,
  output logic             irq
);

  localparam logic [15:0] WAKE_RD = 16'(WAKE_READ_CYC);
  localparam logic [15:0] WAKE_WR = 16'(WAKE_WRITE_CYC);

  logic              wrPend_q;
  logic [7:0]        wrOfs_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        wdata_q;
  logic [IRQ_W-1:0]  irqStat_q;
  logic [IRQ_W-1:0]  irqMask_q;
  logic [IRQ_W-1:0]  events;
  state_type         state_q;
  op_type            op_q;
  logic [1:0]        step_q;
  logic              asleep_q;
  logic              cmdArray_q;
  logic [7:0]        devStat_q;
  logic [7:0]        lastRead_q;
  logic [15:0]       wakeCnt_q;
  logic              busGo_q;
  logic              busWr_q;
  logic [7:0]        busData_q;
  logic              busAct_q;
  logic [7:0]        busCnt_q;
  logic              busDone_q;
  logic [7:0]        rdData_q;
  logic [7:0]        dataSync;
  logic              opGo;
  op_type            opReq;
  logic              sleepGo;
  logic              wakeGo;
  logic              startGo;
  logic              isPE;
  logic              lastStep;
  logic              seqFinish;

  // ============================================================
  // register read decode
  function automatic logic [31:0] readMux(input logic [7:0] ofs);
    unique case (ofs)
      OFS_CTRL:   readMux = {29'h0, op_q};
      OFS_ADDR:   readMux = {12'h000, addr_q};
      OFS_WDATA:  readMux = {24'h000000, wdata_q};
      OFS_STATUS: readMux = {8'h00, lastRead_q, devStat_q, 5'h00, cmdArray_q, asleep_q,
                             (state_q != ST_IDLE)};
      OFS_IRQ:    readMux = {28'h0000000, irqStat_q};
      OFS_MASK:   readMux = {28'h0000000, irqMask_q};
      default:    readMux = 32'h00000000;
    endcase
  endfunction : readMux

  // ============================================================
  // AHB-Lite slave: zero wait, always OKAY, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPend_q  <= 1'b0;
      wrOfs_q   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_q  <= hsel && htrans[1] && hready && hwrite;
      wrOfs_q   <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        hrdata <= readMux(haddr[7:0]);
      end
    end
  end

  // software-written settings
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_q    <= '0;
      wdata_q   <= 8'h00;
      irqMask_q <= '0;
    end else if (wrPend_q) begin
      if (wrOfs_q == OFS_ADDR) addr_q <= hwdata[ADDR_W-1:0];
      if (wrOfs_q == OFS_WDATA) wdata_q <= hwdata[7:0];
      if (wrOfs_q == OFS_MASK) irqMask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // ============================================================
  // op acceptance
  assign opGo    = wrPend_q && (wrOfs_q == OFS_CTRL);
  assign opReq   = op_type'(hwdata[2:0]);
  assign isPE    = (op_q == OP_PROGRAM) || (op_q == OP_ERASE);
  assign sleepGo = opGo && (opReq == OP_SLEEP) && !asleep_q;
  assign wakeGo  = opGo && (opReq == OP_WAKE) && asleep_q;

  always_comb begin
    startGo = 1'b0;
    if (opGo && !asleep_q && state_q == ST_IDLE) begin
      unique case (opReq)
        OP_PROGRAM, OP_ERASE:
          startGo = !devStat_q[BIT_SUPPLY_FAULT] && (wakeCnt_q >= WAKE_WR);
        OP_READ_ARRAY:
          startGo = cmdArray_q ? (wakeCnt_q >= WAKE_RD) : (wakeCnt_q >= WAKE_WR);
        OP_CLEAR, OP_READ_STATUS:
          startGo = (wakeCnt_q >= WAKE_WR);
        OP_NONE, OP_SLEEP, OP_WAKE:
          startGo = 1'b0;
      endcase
    end
  end

  // final step: program/erase poll repeats until ready bit; clear ends on its write, other ops on step one
  always_comb begin
    unique case (op_q)
      OP_PROGRAM, OP_ERASE: lastStep = (step_q == 2'd2) && rdData_q[BIT_READY];
      OP_CLEAR:             lastStep = 1'b1;
      default:              lastStep = (step_q == 2'd1);
    endcase
  end
  assign seqFinish = (state_q == ST_WAIT) && busDone_q && lastStep;

  assign events[IRQ_DONE]  = seqFinish;
  assign events[IRQ_FAIL]  = seqFinish && isPE
                             && (rdData_q[BIT_PROGRAM_FAIL] || rdData_q[BIT_ERASE_FAIL]);
  assign events[IRQ_REFUS] = opGo && (opReq != OP_NONE) && !startGo && !sleepGo && !wakeGo;
  assign events[IRQ_ABORT] = sleepGo && (state_q != ST_IDLE) && isPE;

  // ============================================================
  // interrupt status: write one to clear, a new event wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqStat_q <= '0;
      irq       <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~((wrPend_q && wrOfs_q == OFS_IRQ) ? hwdata[IRQ_W-1:0] : '0))
                   | events;
      irq       <= |(irqStat_q & irqMask_q);
    end
  end

  // ============================================================
  // sequencer: each step drives one pin cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q   <= ST_IDLE;
      op_q      <= OP_NONE;
      step_q    <= 2'd0;
      busGo_q   <= 1'b0;
      busWr_q   <= 1'b0;
      busData_q <= 8'h00;
    end else begin
      busGo_q <= 1'b0;
      if (sleepGo) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE: if (startGo) begin
            op_q    <= opReq;
            step_q  <= (opReq == OP_READ_ARRAY && cmdArray_q) ? 2'd1 : 2'd0;
            state_q <= ST_ISSUE;
          end
          ST_ISSUE: begin
            busGo_q <= 1'b1;
            busWr_q <= (step_q == 2'd0) || (isPE && step_q == 2'd1);
            unique case (op_q)
              OP_PROGRAM:     busData_q <= (step_q == 2'd0) ? CMD_PROG_SETUP : wdata_q;
              OP_ERASE:       busData_q <= (step_q == 2'd0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
              OP_CLEAR:       busData_q <= CMD_CLEAR_STAT;
              OP_READ_STATUS: busData_q <= CMD_READ_STATUS;
              default:        busData_q <= CMD_READ_ARRAY;
            endcase
            state_q <= ST_WAIT;
          end
          ST_WAIT: if (busDone_q) begin
            if (lastStep) begin
              state_q <= ST_IDLE;
            end else begin
              step_q  <= (isPE && step_q == 2'd2) ? 2'd2 : step_q + 2'd1;
              state_q <= ST_ISSUE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // host view of device mode and status
  always_ff @(posedge clk) begin
    if (!nrst) begin
      asleep_q   <= 1'b1;
      cmdArray_q <= 1'b1;
      devStat_q  <= STATUS_INIT;
      lastRead_q <= 8'h00;
      wakeCnt_q  <= 16'h0000;
    end else begin
      if (sleepGo) begin
        asleep_q  <= 1'b1;
        devStat_q <= STATUS_INIT;
      end else if (wakeGo) begin
        asleep_q   <= 1'b0;
        cmdArray_q <= 1'b1;
        wakeCnt_q  <= 16'h0000;
      end else begin
        if (!asleep_q && wakeCnt_q != 16'hFFFF) wakeCnt_q <= wakeCnt_q + 16'h0001;
        // mode moves only on commands this host issues
        // keyed on the op, not the byte: a program byte of FFH is data, not a command
        if (busGo_q && busWr_q && state_q == ST_WAIT) begin
          cmdArray_q <= (op_q == OP_READ_ARRAY);
        end
        if (state_q == ST_WAIT && busDone_q && !busWr_q) begin
          lastRead_q <= rdData_q;
          if (op_q != OP_READ_ARRAY) devStat_q <= rdData_q;
        end
        if (seqFinish && op_q == OP_CLEAR) devStat_q <= devStat_q & ~ERR_MASK;
      end
    end
  end

  // ============================================================
  // pin engine; strobe only inside chip select
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins      <= PINS_RESET;
      busAct_q  <= 1'b0;
      busCnt_q  <= 8'h00;
      busDone_q <= 1'b0;
      rdData_q  <= 8'h00;
    end else begin
      busDone_q <= 1'b0;
      pins.rpN  <= !asleep_q;
      if (asleep_q || sleepGo) begin
        busAct_q     <= 1'b0;
        pins.ceN     <= 1'b1;
        pins.weN     <= 1'b1;
        pins.oeN     <= 1'b1;
        pins.dataOeN <= 1'b1;
      end else if (busGo_q) begin
        busAct_q     <= 1'b1;
        busCnt_q     <= 8'h00;
        pins.ceN     <= 1'b0;
        pins.oeN     <= busWr_q;
        pins.dataOeN <= !busWr_q;
        pins.addr    <= addr_q;
        pins.dataOut <= busData_q;
      end else if (busAct_q) begin
        busCnt_q <= busCnt_q + 8'h01;
        if (busWr_q) begin
          if (busCnt_q == WE_LOW_AT) pins.weN <= 1'b0;
          if (busCnt_q == WE_HIGH_AT) pins.weN <= 1'b1;
          if (busCnt_q == WR_END_AT) begin
            pins.ceN     <= 1'b1;
            pins.dataOeN <= 1'b1;
            busAct_q     <= 1'b0;
            busDone_q    <= 1'b1;
          end
        end else if (busCnt_q == RD_END_AT) begin
          rdData_q  <= dataSync;
          pins.ceN  <= 1'b1;
          pins.oeN  <= 1'b1;
          busAct_q  <= 1'b0;
          busDone_q <= 1'b1;
        end
      end
    end
  end

  flash_pin_sync #(.W(8)) dataSyncInst (
    .clk     (clk),
    .nrst    (nrst),
    .pinIn   (flashDataIn),
    .syncOut (dataSync)
  );

  // ============================================================
  // assertions
  property p_fault_refuse;
    @(posedge clk) disable iff (!nrst)
      (opGo && !asleep_q && state_q == ST_IDLE && devStat_q[BIT_SUPPLY_FAULT]
       && (opReq == OP_PROGRAM || opReq == OP_ERASE)) |=> irqStat_q[IRQ_REFUS] && !busGo_q;
  endproperty
  a_fault_refuse: assert property (p_fault_refuse) else $error("fault did not refuse");

  property p_fail_event;
    @(posedge clk) disable iff (!nrst)
      (seqFinish && isPE && rdData_q[BIT_PROGRAM_FAIL]) |=> irqStat_q[IRQ_FAIL];
  endproperty
  a_fail_event: assert property (p_fail_event) else $error("fail not flagged");

  property p_abort;
    @(posedge clk) disable iff (!nrst)
      (sleepGo && state_q == ST_WAIT && isPE) |=> irqStat_q[IRQ_ABORT] ##1 !pins.rpN && pins.ceN;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not handled");

  property p_sleep_status;
    @(posedge clk) disable iff (!nrst)
      sleepGo |=> devStat_q == STATUS_INIT;
  endproperty
  a_sleep_status: assert property (p_sleep_status) else $error("status not reset");

  property p_wake_mode;
    @(posedge clk) disable iff (!nrst)
      wakeGo |=> cmdArray_q && !asleep_q ##1 pins.rpN;
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake mode wrong");

  property p_we_in_ce;
    @(posedge clk) disable iff (!nrst)
      !pins.weN |-> !pins.ceN && !pins.dataOeN && pins.oeN;
  endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("strobe outside select");

  property p_asleep_quiet;
    @(posedge clk) disable iff (!nrst)
      asleep_q [*2] |-> pins.ceN && pins.weN && pins.oeN && !pins.rpN;
  endproperty
  a_asleep_quiet: assert property (p_asleep_quiet) else $error("pins active asleep");

  property p_wake_delay;
    @(posedge clk) disable iff (!nrst)
      (wakeCnt_q < WAKE_WR && !asleep_q) |-> pins.weN;
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("write before wake delay");

  property p_clear_bits;
    @(posedge clk) disable iff (!nrst)
      (seqFinish && op_q == OP_CLEAR) |=> (devStat_q & ERR_MASK) == 8'h00
        && devStat_q[BIT_READY] == $past(devStat_q[BIT_READY]);
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear status wrong");

  c_program_done: cover property (@(posedge clk) disable iff (!nrst)
    seqFinish && op_q == OP_PROGRAM);
  c_sleep_abort: cover property (@(posedge clk) disable iff (!nrst) events[IRQ_ABORT]);
  c_refused: cover property (@(posedge clk) disable iff (!nrst) events[IRQ_REFUS]);

endmodule : flash_host_ctrl

// ### verif/flash_dev_model.sv
// behavioural byte-wide flash seen from its pins: command decoder, status, small array
// assumes the host pins are registered on clk; only sixteen array bytes are modelled
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_CYC = 30
) (
  input  wire logic           clk,
  input  wire flash_pins_type pins,
  input  wire logic           supplyLow,
  input  wire logic           failNext,
  output logic      [7:0]     flashDataIn
);
  logic [7:0] mem [0:15];
  logic [7:0] sts;
  logic [7:0] lastOut;
  logic       statusMode, progArm, eraseArm, weLast;
  int         busy;
  initial begin
    sts = STATUS_INIT;
    {statusMode, progArm, eraseArm, weLast, busy, lastOut} = '0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // ============================================================
  // command decoder, written on the rising strobe edge
  always @(posedge clk) begin
    weLast <= pins.weN;
    if (!pins.rpN) begin
      sts <= STATUS_INIT;
      {statusMode, progArm, eraseArm} <= '0;
      busy <= 0;
    end else begin
      if (busy == 1) sts[7] <= 1'b1;
      if (busy > 0) busy <= busy - 1;
      if (pins.weN && !weLast && !pins.ceN) begin
        statusMode <= 1'b1;
        if (progArm) begin
          progArm <= 1'b0;
          if (sts[3] || supplyLow) sts[4:3] <= 2'b11;
          else begin
            busy <= BUSY_CYC;
            sts[7] <= 1'b0;
            if (failNext) sts[4] <= 1'b1;
            else mem[pins.addr[3:0]] <= mem[pins.addr[3:0]] & pins.dataOut;
          end
        end else if (eraseArm) begin
          eraseArm <= 1'b0;
          if (pins.dataOut != CMD_CONFIRM) sts[5:4] <= 2'b11;
          else if (sts[3] || supplyLow) sts[5:3] <= 3'b101;
          else begin
            busy <= BUSY_CYC;
            sts[7] <= 1'b0;
            if (failNext) sts[5] <= 1'b1;
            else mem[pins.addr[3:0]] <= 8'hFF;
          end
        end else begin
          case (pins.dataOut)
            8'h40, 8'h10: progArm <= 1'b1;
            CMD_ERASE_SETUP: eraseArm <= 1'b1;
            CMD_CLEAR_STAT: sts[5:3] <= 3'b000;
            CMD_READ_ARRAY: statusMode <= 1'b0;
            default: ;
          endcase
        end
      end
    end
    lastOut <= flashDataIn;
  end
  // ============================================================
  // read path; an undriven bus shows a changing pattern, never a held value
  always_comb begin
    if (!pins.ceN && !pins.oeN && pins.rpN) begin
      flashDataIn = statusMode ? sts : mem[pins.addr[3:0]];
    end else begin
      flashDataIn = ~lastOut;
    end
  end
endmodule : flash_dev_model

// ### verif/tb_top.sv
// self-checking bench for the flash host controller, register tasks over AHB-Lite
// assumes flash_dev_model on the pins; wake counts shortened by parameter
`timescale 1ns/1ps
module tb_top;
  import flash_host_pkg::*;
  logic           clk, nrst, hsel, hwrite, irq, hreadyout, hresp, supplyLow, failNext;
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans;
  logic [7:0]     flashDataIn;
  flash_pins_type pins;
  int             fail_count, checks;

  flash_host_ctrl #(.WAKE_READ_CYC(4), .WAKE_WRITE_CYC(8)) i_flash_host_ctrl (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .flashDataIn(flashDataIn), .irq(irq));
  flash_dev_model i_flash_dev_model (.clk(clk), .pins(pins), .supplyLow(supplyLow),
    .failNext(failNext), .flashDataIn(flashDataIn));

  // ============================================================
  // report and bus tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // bounded wait for hready at a rising edge
  task automatic waitReady();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      if (n++ > 50) begin
        fail_count++;
        close_out();
      end
      @(posedge clk);
    end
  endtask : waitReady
  task automatic xfer(input logic [7:0] ofs, input logic wr, input logic [31:0] val);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= val;
    waitReady();
    rd = hrdata;
  endtask : xfer
  // op issue, then status polling until busy drops; bound counts a mismatch
  task automatic doOp(input logic [2:0] op);
    int n;
    n = 0;
    xfer(OFS_CTRL, 1'b1, {29'h0, op});
    repeat (2) @(posedge clk);
    rd = 32'h1;
    while (rd[0] !== 1'b0) begin
      if (n++ > 300) begin
        fail_count++;
        close_out();
      end
      xfer(OFS_STATUS, 1'b0, 32'h0);
    end
  endtask : doOp
  task automatic prog(input logic [7:0] a, input logic [7:0] d, input logic [2:0] op);
    xfer(OFS_IRQ, 1'b1, 32'h0000000F);
    xfer(OFS_ADDR, 1'b1, {24'h0, a});
    xfer(OFS_WDATA, 1'b1, {24'h0, d});
    doOp(op);
  endtask : prog

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ============================================================
  // main sequence
  initial begin
    {nrst, hsel, hwrite, supplyLow, failNext, fail_count, checks} = '0;
    {haddr, hwdata, htrans} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("asleep after reset", 32'h2, rd & 32'h3);
    chk("irq after reset", 32'h0, {31'h0, irq});
    chk("okay response", 32'h0, {31'h0, hresp});
    xfer(8'h18, 1'b1, 32'hFFFFFFFF);
    xfer(8'h18, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, rd);
    xfer(OFS_MASK, 1'b1, 32'h0000000F);
    xfer(OFS_CTRL, 1'b1, 32'h7);
    doOp(OP_READ_ARRAY);
    xfer(OFS_IRQ, 1'b0, 32'h0);
    chk("early op refused", 32'h4, rd & 32'h4);
    repeat (20) @(posedge clk);
    $display("test reset_wake done");
    // plain program then array read
    prog(8'h03, 8'h5A, OP_PROGRAM);
    chk("program byte", 32'h5A, {24'h0, i_flash_dev_model.mem[3]});
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("status after program", 32'h80, (rd >> 8) & 32'hFF);
    chk("status mode", 32'h0, rd & 32'h4);
    xfer(OFS_IRQ, 1'b0, 32'h0);
    chk("done flag", 32'h1, rd & 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    doOp(OP_READ_ARRAY);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("array read", 32'h5A, (rd >> 16) & 32'hFF);
    chk("array mode", 32'h4, rd & 32'h4);
    doOp(OP_READ_STATUS);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("read status value", 32'h8080, (rd >> 8) & 32'hFFFF);
    chk("mode after read status", 32'h0, rd & 32'h4);
    $display("test program done");
    // supply fault blocks programming until cleared
    supplyLow <= 1'b1;
    prog(8'h04, 8'h11, OP_PROGRAM);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("supply fault bit", 32'h8, (rd >> 8) & 32'h8);
    supplyLow <= 1'b0;
    prog(8'h04, 8'h11, OP_PROGRAM);
    xfer(OFS_IRQ, 1'b0, 32'h0);
    chk("refused while fault", 32'h4, rd & 32'h4);
    chk("no write while fault", 32'hFF, {24'h0, i_flash_dev_model.mem[4]});
    doOp(OP_CLEAR);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("clear keeps ready", 32'h80, (rd >> 8) & 32'hB8);
    prog(8'h04, 8'h11, OP_PROGRAM);
    chk("retry written", 32'h11, {24'h0, i_flash_dev_model.mem[4]});
    $display("test supply_fault done");
    // device failures on program and on erase
    for (int k = 0; k < 2; k++) begin
      failNext <= 1'b1;
      prog(8'h05, 8'hFF, (k == 0) ? OP_PROGRAM : OP_ERASE);
      failNext <= 1'b0;
      xfer(OFS_STATUS, 1'b0, 32'h0);
      chk("fail bit", 32'h1000 << k, rd & (32'h1000 << k));
      chk("mode after fail", 32'h0, rd & 32'h4);
      xfer(OFS_IRQ, 1'b0, 32'h0);
      chk("fail flag", 32'h2, rd & 32'h2);
      doOp(OP_CLEAR);
    end
    $display("test device_fail done");
    // power-down in mid-erase
    xfer(OFS_IRQ, 1'b1, 32'h0000000F);
    xfer(OFS_ADDR, 1'b1, 32'h6);
    xfer(OFS_CTRL, 1'b1, {29'h0, OP_ERASE});
    repeat (35) @(posedge clk);
    xfer(OFS_CTRL, 1'b1, {29'h0, OP_SLEEP});
    repeat (4) @(posedge clk);
    chk("device status reinit", 32'h80, {24'h0, i_flash_dev_model.sts});
    chk("power-down pin", 32'h0, {31'h0, pins.rpN});
    xfer(OFS_IRQ, 1'b0, 32'h0);
    chk("abort flag", 32'h8, rd & 32'h8);
    xfer(OFS_STATUS, 1'b0, 32'h0);
    chk("host status reinit", 32'h80, (rd >> 8) & 32'hFF);
    xfer(OFS_MASK, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    xfer(OFS_MASK, 1'b1, 32'h8);
    repeat (3) @(posedge clk);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    xfer(OFS_IRQ, 1'b1, 32'h0000000F);
    repeat (3) @(posedge clk);
    chk("cleared irq", 32'h0, {31'h0, irq});
    $display("test abort done");
    close_out();
  end
endmodule : tb_top
